// ===== hw/pfm_pkg.sv
// Package: offsets, field positions, reset values and timing counts for the mode registers
package pfm_pkg;
	// Configuration index values that select each register
	localparam logic [7:0] PFM_IDX_PIN_FLOPPY = 8'h03;
	localparam logic [7:0] PFM_IDX_PAR_SERIAL = 8'h04;
	// Power-up values
	localparam logic [7:0] PFM_RST_PIN_FLOPPY = 8'h70;
	localparam logic [7:0] PFM_RST_PAR_SERIAL = 8'h00;
	// Writable bits; the rest read as zero
	localparam logic [7:0] PFM_MASK_PIN_FLOPPY = 8'hF7;
	localparam logic [7:0] PFM_MASK_PAR_SERIAL = 8'h7F;
	// Pin and floppy mode fields
	localparam int PFM_PF_GAME_SEL = 0;
	localparam int PFM_PF_ENH_MODE2 = 1;
	localparam int PFM_PF_CLKRUN_SEL = 2;
	localparam int PFM_PF_DENSITY_FORCE = 4;
	localparam int PFM_PF_FORMAT = 5;
	localparam int PFM_PF_IDENTITY = 6;
	localparam int PFM_PF_SHARED_EN = 7;
	// Parallel and serial setup fields
	localparam int PFM_PS_PAR_MODE_LO = 0;
	localparam int PFM_PS_PFD_LO = 2;
	localparam int PFM_PS_MUSIC_ONE = 4;
	localparam int PFM_PS_MUSIC_TWO = 5;
	localparam int PFM_PS_EPP_TYPE = 6;
	// Parallel mode codes
	localparam logic [1:0] PFM_PAR_SPP = 2'h0;
	localparam logic [1:0] PFM_PAR_EPP_SPP = 2'h1;
	localparam logic [1:0] PFM_PAR_ECP = 2'h2;
	localparam logic [1:0] PFM_PAR_ECP_EPP = 2'h3;
	localparam logic [2:0] PFM_ECR_EPP = 3'h4;
	// Parallel floppy codes
	localparam logic [1:0] PFM_PFD_ONE = 2'h1;
	localparam logic [1:0] PFM_PFD_TWO = 2'h2;
	// Music clock rate
	localparam longint PFM_CLK_HZ = 100000000;
	localparam longint PFM_MUSIC_HZ = 125000;
	localparam int PFM_MUSIC_DIV = int'(PFM_CLK_HZ / PFM_MUSIC_HZ);
endpackage : pfm_pkg

// ===== hw/pfm_rate_div.sv
// Divider that makes the one-cycle music rate enable pulse
module pfm_rate_div
	import pfm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Enable pulse out
	output logic tick_ff
);
	logic [9:0] cnt_ff;
	logic [9:0] nxt_cnt;
	logic nxt_tick;

	// Count down; pulse on wrap
	always_comb begin
		nxt_tick = 1'b0;
		if (cnt_ff == 10'h000) begin
			nxt_cnt = 10'(PFM_MUSIC_DIV - 1);
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff - 10'h001;
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 10'h000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end
endmodule : pfm_rate_div

// ===== hw/pfm_mode_regs.sv
// Pin/floppy mode and parallel/serial setup registers with their decoded controls
//
// Contract
// - Pin register reachable only config state, index 03h
// - Pin register powers up as 70h
// - Bit 1 selects enhanced floppy mode two
// - Bit 4 forces density output high
// - Identity and format bits pick interface mode
// - Bits 7,2 select shared pin; tristated initially
// - Setup register reachable only config state, index 04h
// - Setup register powers up as 00h
// - Parallel mode field needs printer bit low
// - Field codes: SPP, EPP+SPP, ECP, ECP+EPP
// - Bit 4 gives first port music clock
// - Bit 5 gives second port music clock
// - Printer bit high means plain printer mode
// - Floppy tristate overrides density control
// - ECP+EPP allows EPP via ECR 100
// - Music clock is 125 kHz rate
module pfm_mode_regs
	import pfm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration access
	input wire logic cfg_state,
	input wire logic [7:0] cfg_index,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata_ff,
	output logic cfg_rvalid_ff,
	// Controls from other configuration registers and cores
	input wire logic printer_mode,
	input wire logic fdc_out_tristate,
	input wire logic [2:0] ecr_mode,
	input wire logic drive_density_value,
	input wire logic address_extension_value,
	input wire logic clock_run_value,
	input wire logic baud_tick,
	// Floppy controls
	output logic enhanced_floppy_mode2_ff,
	output logic [1:0] floppy_iface_mode_ff,
	output logic drive_density_out_one_ff,
	output logic drive_density_out_one_oe_ff,
	// Shared pins
	output logic game_port_select_ff,
	output logic shared_pin_out_ff,
	output logic shared_pin_oe_ff,
	output logic clock_run_select_ff,
	// Parallel port controls
	output logic [1:0] par_mode_ff,
	output logic epp_active_ff,
	output logic epp_v17_ff,
	output logic parallel_floppy_mode_one_ff,
	output logic parallel_floppy_mode_two_ff,
	// Serial clock enables
	output logic serial_one_tick_ff,
	output logic serial_two_tick_ff
);
	// Register state and next values
	logic [7:0] pin_and_floppy_mode_config_ff;
	logic [7:0] parallel_serial_extended_setup_ff;
	logic [7:0] nxt_pin_and_floppy_mode_config;
	logic [7:0] nxt_parallel_serial_extended_setup;
	logic [7:0] nxt_cfg_rdata;
	logic nxt_cfg_rvalid;
	// Index hits and the shared music rate
	logic sel_pin;
	logic sel_par;
	logic music_tick;

	// Register selection by config state and index
	assign sel_pin = cfg_state && (cfg_index == PFM_IDX_PIN_FLOPPY);
	assign sel_par = cfg_state && (cfg_index == PFM_IDX_PAR_SERIAL);

	// Music rate source shared by both serial ports
	pfm_rate_div u_rate_div (
		.clk(clk),
		.rst(rst),
		.tick_ff(music_tick)
	);

	// Register writes and reads; reserved bits masked to zero
	always_comb begin
		nxt_pin_and_floppy_mode_config = pin_and_floppy_mode_config_ff;
		nxt_parallel_serial_extended_setup = parallel_serial_extended_setup_ff;
		nxt_cfg_rdata = cfg_rdata_ff;
		nxt_cfg_rvalid = 1'b0;
		// Writes need config state and a matching index
		if (cfg_wr && sel_pin) begin
			nxt_pin_and_floppy_mode_config = cfg_wdata & PFM_MASK_PIN_FLOPPY;
		end
		if (cfg_wr && sel_par) begin
			nxt_parallel_serial_extended_setup = cfg_wdata & PFM_MASK_PAR_SERIAL;
		end
		// A read in the same cycle as a write returns the old value
		if (cfg_rd && sel_pin) begin
			nxt_cfg_rdata = pin_and_floppy_mode_config_ff;
			nxt_cfg_rvalid = 1'b1;
		end else if (cfg_rd && sel_par) begin
			nxt_cfg_rdata = parallel_serial_extended_setup_ff;
			nxt_cfg_rvalid = 1'b1;
		end
	end

	// Register state; reset loads power-up values
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_and_floppy_mode_config_ff <= PFM_RST_PIN_FLOPPY;
			parallel_serial_extended_setup_ff <= PFM_RST_PAR_SERIAL;
			cfg_rdata_ff <= 8'h00;
			cfg_rvalid_ff <= 1'b0;
		end else begin
			pin_and_floppy_mode_config_ff <= nxt_pin_and_floppy_mode_config;
			parallel_serial_extended_setup_ff <= nxt_parallel_serial_extended_setup;
			cfg_rdata_ff <= nxt_cfg_rdata;
			cfg_rvalid_ff <= nxt_cfg_rvalid;
		end
	end

	// Decoded controls, one cycle behind the registers
	logic nxt_enh;
	logic [1:0] nxt_iface;
	logic nxt_den;
	logic nxt_den_oe;
	logic nxt_game;
	logic nxt_sh_out;
	logic nxt_sh_oe;
	logic nxt_clkrun_sel;
	logic [1:0] nxt_par_mode;
	logic nxt_epp;
	logic nxt_v17;
	logic nxt_pfd1;
	logic nxt_pfd2;
	logic nxt_ser1;
	logic nxt_ser2;

	// Field slices of the setup register
	logic [1:0] par_field;
	logic [1:0] pfd_field;

	// Decode of both registers into control levels
	always_comb begin
		// Field slices shared by several decodes
		par_field = parallel_serial_extended_setup_ff[PFM_PS_PAR_MODE_LO +: 2];
		pfd_field = parallel_serial_extended_setup_ff[PFM_PS_PFD_LO +: 2];

		// Floppy controller modes
		nxt_enh = pin_and_floppy_mode_config_ff[PFM_PF_ENH_MODE2];
		// Identity in high bit, format in low: 11 compat, 10 reserved, 01 second, 00 third
		nxt_iface = {pin_and_floppy_mode_config_ff[PFM_PF_IDENTITY],
			pin_and_floppy_mode_config_ff[PFM_PF_FORMAT]};

		// Floppy tristate wins; density control then has no effect
		nxt_den_oe = !fdc_out_tristate;
		// Value kept even while undriven; harmless at the pin
		nxt_den = pin_and_floppy_mode_config_ff[PFM_PF_DENSITY_FORCE] | drive_density_value;

		// Shared pin routing
		nxt_game = pin_and_floppy_mode_config_ff[PFM_PF_GAME_SEL];
		// Reserved selection keeps the shared pin undriven, as after reset
		nxt_sh_oe = pin_and_floppy_mode_config_ff[PFM_PF_SHARED_EN];
		nxt_clkrun_sel = nxt_sh_oe && pin_and_floppy_mode_config_ff[PFM_PF_CLKRUN_SEL];
		nxt_sh_out = nxt_clkrun_sel ? clock_run_value : address_extension_value;

		// Printer mode masks the extended field entirely
		nxt_par_mode = printer_mode ? PFM_PAR_SPP : par_field;
		// Combined mode gives EPP only when the ECP control selects it
		nxt_epp = (nxt_par_mode == PFM_PAR_EPP_SPP) ||
			((nxt_par_mode == PFM_PAR_ECP_EPP) && (ecr_mode == PFM_ECR_EPP));
		nxt_v17 = parallel_serial_extended_setup_ff[PFM_PS_EPP_TYPE];

		// Reserved code 11 leaves the port in normal mode
		nxt_pfd1 = (pfd_field == PFM_PFD_ONE);
		nxt_pfd2 = (pfd_field == PFM_PFD_TWO);

		// One divider feeds both ports; saves a second counter
		nxt_ser1 = parallel_serial_extended_setup_ff[PFM_PS_MUSIC_ONE] ? music_tick : baud_tick;
		nxt_ser2 = parallel_serial_extended_setup_ff[PFM_PS_MUSIC_TWO] ? music_tick : baud_tick;
	end

	// Output registers; shared pin undriven from reset
	always_ff @(posedge clk) begin
		if (rst) begin
			// Density pin undriven until the first decode
			enhanced_floppy_mode2_ff <= 1'b0;
			floppy_iface_mode_ff <= 2'h3;
			drive_density_out_one_ff <= 1'b1;
			drive_density_out_one_oe_ff <= 1'b0;
			game_port_select_ff <= 1'b0;
			shared_pin_out_ff <= 1'b0;
			shared_pin_oe_ff <= 1'b0;
			clock_run_select_ff <= 1'b0;
			par_mode_ff <= PFM_PAR_SPP;
			epp_active_ff <= 1'b0;
			epp_v17_ff <= 1'b0;
			parallel_floppy_mode_one_ff <= 1'b0;
			parallel_floppy_mode_two_ff <= 1'b0;
			serial_one_tick_ff <= 1'b0;
			serial_two_tick_ff <= 1'b0;
		end else begin
			enhanced_floppy_mode2_ff <= nxt_enh;
			floppy_iface_mode_ff <= nxt_iface;
			drive_density_out_one_ff <= nxt_den;
			drive_density_out_one_oe_ff <= nxt_den_oe;
			game_port_select_ff <= nxt_game;
			shared_pin_out_ff <= nxt_sh_out;
			shared_pin_oe_ff <= nxt_sh_oe;
			clock_run_select_ff <= nxt_clkrun_sel;
			par_mode_ff <= nxt_par_mode;
			epp_active_ff <= nxt_epp;
			epp_v17_ff <= nxt_v17;
			parallel_floppy_mode_one_ff <= nxt_pfd1;
			parallel_floppy_mode_two_ff <= nxt_pfd2;
			serial_one_tick_ff <= nxt_ser1;
			serial_two_tick_ff <= nxt_ser2;
		end
	end
endmodule : pfm_mode_regs

// ===== verification/pfm_mode_regs_properties.sv
// Checker for mode register access, refusal and decode timing
module pfm_mode_regs_properties
	import pfm_pkg::*;
(
	// Clock, reset, access
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_state,
	input wire logic [7:0] cfg_index,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata_ff,
	input wire logic cfg_rvalid_ff,
	// Controls and decoded outputs
	input wire logic printer_mode,
	input wire logic fdc_out_tristate,
	input wire logic drive_density_out_one_oe_ff,
	input wire logic shared_pin_oe_ff,
	input wire logic [1:0] par_mode_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Accepted access per register
	wire logic hit3 = cfg_state && cfg_index == PFM_IDX_PIN_FLOPPY;
	wire logic hit4 = cfg_state && cfg_index == PFM_IDX_PAR_SERIAL;
	read_ok_a: assert property (cfg_rd && (hit3 || hit4) |=> cfg_rvalid_ff) else $error("no rvalid");
	read_refuse_a: assert property (!(cfg_rd && (hit3 || hit4)) |=> !cfg_rvalid_ff) else $error("rvalid");
	pin_bit3_a: assert property (cfg_rd && hit3 |=> !cfg_rdata_ff[3]) else $error("bit3 set");
	setup_bit7_a: assert property (cfg_rd && hit4 |=> !cfg_rdata_ff[7]) else $error("bit7 set");
	shared_oe_a: assert property (cfg_wr && hit3 |-> ##2 shared_pin_oe_ff == $past(cfg_wdata[7], 2))
		else $error("shared oe");
	// Tristated floppy outputs leave the density pin undriven
	dens_oe_a: assert property (!$past(rst) |-> drive_density_out_one_oe_ff == !$past(fdc_out_tristate))
		else $error("density oe");
	printer_mode_a: assert property (!$past(rst) && $past(printer_mode) |-> par_mode_ff == 2'h0)
		else $error("par mode");
	// Checked during reset itself, so the default disable is overridden
	reset_idle_a: assert property (disable iff (1'b0) rst |=> !shared_pin_oe_ff && !cfg_rvalid_ff)
		else $error("reset");
	cover property (cfg_wr && hit3);
	cover property (cfg_rd && hit4);
	cover property (!printer_mode && par_mode_ff == 2'h3);
endmodule : pfm_mode_regs_properties

bind pfm_mode_regs pfm_mode_regs_properties u_props (
	.clk(clk), .rst(rst), .cfg_state(cfg_state), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff), .cfg_rvalid_ff(cfg_rvalid_ff),
	.printer_mode(printer_mode), .fdc_out_tristate(fdc_out_tristate),
	.drive_density_out_one_oe_ff(drive_density_out_one_oe_ff), .shared_pin_oe_ff(shared_pin_oe_ff),
	.par_mode_ff(par_mode_ff)
);

// ===== verification/tb.sv
// Self-checking bench for the mode registers
module tb
	import pfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, cfg_state = 0, cfg_wr = 0, cfg_rd = 0, printer_mode = 1, fdc_out_tristate = 0;
	logic drive_density_value = 0, address_extension_value = 0, clock_run_value = 0, baud_tick = 0;
	logic [7:0] cfg_index = 0, cfg_wdata = 0, cfg_rdata_ff, m3 = 8'h70, m4 = 8'h00;
	logic [2:0] ecr_mode = 0;
	logic [1:0] floppy_iface_mode_ff, par_mode_ff;
	logic cfg_rvalid_ff, enhanced_floppy_mode2_ff, drive_density_out_one_ff, drive_density_out_one_oe_ff;
	logic game_port_select_ff, shared_pin_out_ff, shared_pin_oe_ff, clock_run_select_ff, epp_active_ff;
	logic epp_v17_ff, parallel_floppy_mode_one_ff, parallel_floppy_mode_two_ff, serial_one_tick_ff, serial_two_tick_ff;
	int n_errors = 0, n_compared = 0, n, n2;
	pfm_mode_regs uut (
		.clk(clk), .rst(rst), .cfg_state(cfg_state), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff), .cfg_rvalid_ff(cfg_rvalid_ff),
		.printer_mode(printer_mode), .fdc_out_tristate(fdc_out_tristate), .ecr_mode(ecr_mode),
		.drive_density_value(drive_density_value), .address_extension_value(address_extension_value),
		.clock_run_value(clock_run_value), .baud_tick(baud_tick),
		.enhanced_floppy_mode2_ff(enhanced_floppy_mode2_ff), .floppy_iface_mode_ff(floppy_iface_mode_ff),
		.drive_density_out_one_ff(drive_density_out_one_ff),
		.drive_density_out_one_oe_ff(drive_density_out_one_oe_ff),
		.game_port_select_ff(game_port_select_ff), .shared_pin_out_ff(shared_pin_out_ff),
		.shared_pin_oe_ff(shared_pin_oe_ff), .clock_run_select_ff(clock_run_select_ff),
		.par_mode_ff(par_mode_ff), .epp_active_ff(epp_active_ff), .epp_v17_ff(epp_v17_ff),
		.parallel_floppy_mode_one_ff(parallel_floppy_mode_one_ff),
		.parallel_floppy_mode_two_ff(parallel_floppy_mode_two_ff),
		.serial_one_tick_ff(serial_one_tick_ff), .serial_two_tick_ff(serial_two_tick_ff)
	);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	// One strobe then an idle cycle, so no strobe is set twice in a step
	task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
		cfg_state = s;
		cfg_index = i;
		cfg_wdata = d;
		cfg_wr = 1;
		@(posedge clk);
		#1 cfg_wr = 0;
		if (s && i == 3) m3 = d & 8'hF7;
		if (s && i == 4) m4 = d & 8'h7F;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic s, input logic [7:0] i);
		cfg_state = s;
		cfg_index = i;
		cfg_rd = 1;
		@(posedge clk);
		#1 cfg_rd = 0;
		chk(cfg_rvalid_ff, s && (i == 3 || i == 4));
		if (s && i == 3) chk(cfg_rdata_ff, m3);
		if (s && i == 4) chk(cfg_rdata_ff, m4);
		@(posedge clk);
		#1;
	endtask : rd
	// Compare every decoded output except the two serial clock enables with the model
	task automatic dec;
		logic [1:0] pm;
		pm = printer_mode ? 2'h0 : m4[1:0];
		chk(enhanced_floppy_mode2_ff, m3[1]);
		chk(drive_density_out_one_ff, m3[4] | drive_density_value);
		chk(drive_density_out_one_oe_ff, !fdc_out_tristate);
		chk(floppy_iface_mode_ff, m3[6:5]);
		chk(game_port_select_ff, m3[0]);
		chk(shared_pin_oe_ff, m3[7]);
		chk(clock_run_select_ff, m3[7] & m3[2]);
		chk(shared_pin_out_ff, (m3[7] & m3[2]) ? clock_run_value : address_extension_value);
		chk(par_mode_ff, pm);
		chk(epp_active_ff, pm == 1 || (pm == 3 && ecr_mode == 4));
		chk(epp_v17_ff, m4[6]);
		chk(parallel_floppy_mode_one_ff, m4[3:2] == 1);
		chk(parallel_floppy_mode_two_ff, m4[3:2] == 2);
	endtask : dec
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	// Watchdog in case the run hangs
	initial begin
		#100000;
		n_errors++;
		results;
	end
	initial begin
		n = $urandom(32'h5AC8);
		repeat (6) @(posedge clk);
		#1 rst = 0;
		rd(1, 3);
		rd(1, 4);
		chk(shared_pin_oe_ff, 0);
		$display("reset done");
		wr(0, 3, 8'hFF);
		wr(1, 5, 8'hFF);
		rd(0, 4);
		rd(1, 2);
		rd(1, 3);
		$display("refuse done");
		// Loop index walks every mode code, printer bit and EPP select
		for (int i = 0; i < 32; i++) begin
			wr(1, 3, 8'($urandom));
			wr(1, 4, {4'($urandom), i[3:0]});
			printer_mode = i[4];
			ecr_mode = i[2] ? 3'h4 : 3'($urandom);
			{fdc_out_tristate, drive_density_value, address_extension_value, clock_run_value} = 4'($urandom);
			@(posedge clk);
			#1 dec;
			rd(1, 3);
			rd(1, 4);
		end
		$display("decode done");
		wr(1, 4, 8'h00);
		baud_tick = 1;
		@(posedge clk);
		#1 baud_tick = 0;
		chk(serial_one_tick_ff, 1);
		chk(serial_two_tick_ff, 1);
		// Each port alone, then both, over two music periods
		for (int k = 1; k < 4; k++) begin
			wr(1, 4, 8'(k * 16));
			n = 0;
			n2 = 0;
			repeat (2 * PFM_MUSIC_DIV) begin
				@(posedge clk);
				#1 n += serial_one_tick_ff;
				n2 += serial_two_tick_ff;
			end
			chk(8'(n), k[0] ? 8'h02 : 8'h00);
			chk(8'(n2), k[1] ? 8'h02 : 8'h00);
		end
		$display("clock done");
		results;
	end
endmodule : tb
